// *** verilog/elc_ctrl.sv ***
// Exception arbitration and low-power mode control with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "elc_map.svh"

// Overview of operation
// - Stop instruction clears and holds recovery counter
// - Recovery lasts 32 or 4096 crystal cycles
// - Sample short-recovery bit when stop ends
// - Pin reset spares counter; free-running otherwise
// - Entry sets interrupt mask; return clears it
// - Latch and arbitrate once; no preemption
// - Take interrupt after instruction when unmasked, enabled
// - Highest priority pending source wins
// - Pending interrupt served before resuming program
// - Software interrupt ignores the mask
// - Software stacks PC, hardware PC minus one
// - Resets outrank interrupts, never arbitrated
// - Break request forces software interrupt vector
// - Break flag clears allowed only with enable
// - Flag cleared in break stays cleared
// - Two-step clears stay guarded through break
// - Wait or stop clears mask, stops core
// - Wait stops core clocks; wake after one cycle
// - Break ending wait sets break-wait flag
// - Watchdog stays active in wait when enabled
// - Stop gates clocks; wake after recovery delay
// - Break-wait flag cleared by zero write, reset
// - Twelve-bit counter on crystal falling edge
module elc_ctrl #(
  parameter int IRQ_N     = 8,
  parameter int REC_LONG  = `ELC_REC_LONG,
  parameter int REC_SHORT = `ELC_REC_SHORT
) (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                pin_rst_i,
  input  wire logic                int_rst_i,
  input  wire logic                crystal_clock_i,
  input  wire logic [IRQ_N-1:0]    irq_i,
  input  wire logic                break_req_i,
  input  wire elc_pkg::elc_cpu_evt_t cpu_evt_i,
  input  wire logic                flag_clr_req_i,
  output logic                     flag_clr_ok_o,
  output logic                     in_break_o,
  output logic                     int_mask_o,
  output elc_pkg::elc_irq_sel_t    irq_sel_o,
  output logic                     pc_minus_one_o,
  output logic                     cpu_clk_en_o,
  output logic                     periph_clk_en_o,
  output logic                     base_clock_out_en_o,
  output logic                     crystal_clock_en_o,
  output logic                     watchdog_run_o,
  output logic [11:0]              rec_count_o,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import elc_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [1:0]       xclk_sync_reg;
  logic [IRQ_N-1:0] irq_s1_reg;
  logic [IRQ_N-1:0] irq_s2_reg;
  logic [1:0]       brk_sync_reg;
  logic [1:0]       pin_sync_reg;
  logic             xclk_prev_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xclk_sync_reg <= 2'h0;
      irq_s1_reg    <= '0;
      irq_s2_reg    <= '0;
      brk_sync_reg  <= 2'h0;
      pin_sync_reg  <= 2'h0;
      xclk_prev_reg <= 1'b0;
    end else begin
      xclk_sync_reg <= {xclk_sync_reg[0], crystal_clock_i};
      irq_s1_reg    <= irq_i;
      irq_s2_reg    <= irq_s1_reg;
      brk_sync_reg  <= {brk_sync_reg[0], break_req_i};
      pin_sync_reg  <= {pin_sync_reg[0], pin_rst_i};
      xclk_prev_reg <= xclk_sync_reg[1];
    end
  end

  // Crystal clock sampled on the fast clock; a falling edge is a tick
  wire xclk_fall = xclk_prev_reg & ~xclk_sync_reg[1];
  wire brk_s     = brk_sync_reg[1];
  wire pin_rst_s = pin_sync_reg[1];
  wire [IRQ_N-1:0] irq_s = irq_s2_reg;

  // ==========================================================
  // Registers and mode state
  // ==========================================================
  logic [7:0]       brk_status_reg;
  logic [7:0]       brk_flag_ctl_reg;
  logic [7:0]       config_reg;
  logic [IRQ_N-1:0] int_enable_reg;
  logic [11:0]      rec_cnt_reg;
  logic             short_stop_recovery_sel_lat_reg;
  logic             mask_reg;
  logic             break_reg;
  logic             wake_reg;
  elc_irq_sel_t     latch_reg;
  elc_mode_t        mode_reg;
  elc_mode_t        mode_next;

  wire break_flag_clear_enable     = brk_flag_ctl_reg[`ELC_BIT_BREAK_FLAG_CLEAR_ENABLE];
  wire short_stop_recovery_sel    = config_reg[`ELC_BIT_SHORT_STOP_RECOVERY_SEL];
  wire wdog_dis = config_reg[`ELC_BIT_WDOG_DIS];

  // ==========================================================
  // Arbitration
  // ==========================================================
  wire [IRQ_N-1:0] hw_req = irq_s & int_enable_reg;
  logic [2:0] hw_vec;
  always_comb begin
    hw_vec = 3'h0;
    // Lowest index is highest priority
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (hw_req[i]) begin
        hw_vec = i[2:0];
      end
    end
  end

  wire in_run     = (mode_reg == ELC_RUN);
  wire hw_take    = |hw_req & ~mask_reg;
  wire brk_take   = brk_s & ~break_reg;
  // Break uses the software-interrupt vector, never gated by the mask
  wire sw_take    = cpu_evt_i.swi_exec | brk_take;
  // A reset holds off every latch so it is never arbitrated
  wire any_rst    = int_rst_i | pin_rst_s;
  wire take_point = cpu_evt_i.instr_done | wake_reg;
  // A software interrupt is its own completion point; others wait
  wire do_latch   = ~latch_reg.valid & ~any_rst &
                    (cpu_evt_i.swi_exec |
                     take_point & (brk_take | hw_take));
  wire rec_len_hit = short_stop_recovery_sel_lat_reg ?
                     (rec_cnt_reg == 12'(REC_SHORT - 1)) :
                     (rec_cnt_reg == 12'(REC_LONG - 1));
  wire wake_wait  = (|hw_req) | brk_s;
  wire wake_stop  = |irq_s | brk_s;

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      ELC_RUN: begin
        if (cpu_evt_i.stop_exec) begin
          mode_next = ELC_STOP;
        end else if (cpu_evt_i.wait_exec) begin
          mode_next = ELC_WAIT;
        end
      end
      ELC_WAIT: begin
        if (wake_wait) begin
          mode_next = ELC_RUN;
        end
      end
      ELC_STOP: begin
        if (wake_stop) begin
          mode_next = ELC_REC;
        end
      end
      ELC_REC: begin
        if (xclk_fall & rec_len_hit) begin
          mode_next = ELC_RUN;
        end
      end
    endcase
  end

  // Mode, mask, latch and recovery counter
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_reg      <= ELC_RUN;
      mask_reg      <= 1'b1;
      latch_reg     <= '0;
      rec_cnt_reg   <= 12'h000;
      short_stop_recovery_sel_lat_reg <= 1'b0;
      break_reg     <= 1'b0;
      wake_reg      <= 1'b0;
    end else begin
      // Internal reset aborts a pending mode and restarts from run
      if (int_rst_i) begin
        mode_reg <= ELC_RUN;
      end else begin
        mode_reg <= mode_next;
      end
      // Leaving wait takes the interrupt one cycle later
      wake_reg <= (mode_reg == ELC_WAIT) & (mode_next == ELC_RUN);
      if (mode_reg == ELC_STOP && mode_next == ELC_REC) begin
        short_stop_recovery_sel_lat_reg <= short_stop_recovery_sel;
      end
      if (int_rst_i || (in_run && cpu_evt_i.stop_exec) ||
          mode_reg == ELC_STOP) begin
        rec_cnt_reg <= 12'h000;
      end else if (xclk_fall) begin
        // External pin reset leaves the count running
        rec_cnt_reg <= rec_cnt_reg + 12'h001;
      end
      if (any_rst) begin
        latch_reg <= '0;
      end else if (do_latch) begin
        latch_reg.valid <= 1'b1;
        latch_reg.is_sw <= sw_take;
        latch_reg.vec   <= sw_take ? 3'h7 : hw_vec;
      end else if (cpu_evt_i.int_ack || ~mask_reg & ~latch_reg.is_sw &
                   ~(|hw_req)) begin
        latch_reg.valid <= 1'b0;
      end
      if (any_rst) begin
        mask_reg <= 1'b1;
      end else if (cpu_evt_i.int_ack) begin
        mask_reg <= 1'b1;
      end else if (cpu_evt_i.rti_exec || cpu_evt_i.wait_exec ||
                   cpu_evt_i.stop_exec) begin
        mask_reg <= 1'b0;
      end
      if (brk_take && do_latch) begin
        break_reg <= 1'b1;
      end else if (~brk_s && cpu_evt_i.rti_exec) begin
        break_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs to core and clock unit
  // ==========================================================
  assign int_mask_o      = mask_reg;
  assign irq_sel_o       = latch_reg;
  assign pc_minus_one_o  = latch_reg.valid & ~latch_reg.is_sw;
  assign in_break_o      = break_reg;
  // Two-step clears are qualified here too, so a first step taken
  // before break cannot complete in break unless break_flag_clear_enable is set
  wire clr_gate = ~break_reg | break_flag_clear_enable;
  assign flag_clr_ok_o   = flag_clr_req_i & clr_gate;
  assign cpu_clk_en_o    = in_run;
  assign periph_clk_en_o = in_run | (mode_reg == ELC_WAIT);
  assign base_clock_out_en_o = (mode_reg != ELC_STOP);
  assign crystal_clock_en_o  = (mode_reg != ELC_STOP);
  assign watchdog_run_o  = ~wdog_dis & (mode_reg != ELC_STOP);
  assign rec_count_o     = rec_cnt_reg;

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic [1:0]  bresp_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        bvalid_reg;
  logic        rvalid_reg;

  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  wire aw_ok = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
  wire w_ok  = w_hold_reg | (s_axi_wvalid & s_axi_wready);
  wire [7:0]  wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire        wl = w_hold_reg ? wstrb_reg[0] : s_axi_wstrb[0];
  wire do_wr = aw_ok & w_ok & ~bvalid_reg;
  wire wr_bs = do_wr & wl & (wa == `ELC_OFS_BRK_STATUS);
  wire wr_fc = do_wr & wl & (wa == `ELC_OFS_BRK_FLAG_CTL);
  wire wr_cf = do_wr & wl & (wa == `ELC_OFS_CONFIG);
  wire wr_ie = do_wr & wl & (wa == `ELC_OFS_INT_ENABLE);
  wire wr_hit = (wa == `ELC_OFS_BRK_STATUS) | (wa == `ELC_OFS_BRK_FLAG_CTL) |
                (wa == `ELC_OFS_CONFIG) | (wa == `ELC_OFS_INT_ENABLE);
  wire bw_set = (mode_reg == ELC_WAIT) & brk_s;
  wire bw_clr = wr_bs & ~wd[`ELC_BIT_BRK_WAIT];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register storage; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      brk_status_reg   <= `ELC_RST_BRK_STATUS;
      brk_flag_ctl_reg <= `ELC_RST_BRK_FLAG_CTL;
      config_reg       <= `ELC_RST_CONFIG;
      int_enable_reg   <= '0;
    end else begin
      if (int_rst_i || pin_rst_s) begin
        brk_status_reg <= `ELC_RST_BRK_STATUS;
      end else if (bw_set) begin
        brk_status_reg[`ELC_BIT_BRK_WAIT] <= 1'b1;
      end else if (bw_clr) begin
        brk_status_reg[`ELC_BIT_BRK_WAIT] <= 1'b0;
      end
      if (wr_fc) begin
        brk_flag_ctl_reg <= {7'h00, wd[`ELC_BIT_BREAK_FLAG_CLEAR_ENABLE]};
      end
      if (wr_cf) begin
        config_reg <= {6'h00, wd[1:0]};
      end
      if (wr_ie) begin
        int_enable_reg <= wd[IRQ_N-1:0];
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      `ELC_OFS_BRK_STATUS:   rd_mux = {24'h0, brk_status_reg};
      `ELC_OFS_BRK_FLAG_CTL: rd_mux = {24'h0, brk_flag_ctl_reg};
      `ELC_OFS_CONFIG:       rd_mux = {24'h0, config_reg};
      `ELC_OFS_CPU_STATE:    rd_mux = {16'h0, rec_cnt_reg, mode_reg};
      `ELC_OFS_INT_ENABLE:   rd_mux = 32'(int_enable_reg);
      `ELC_OFS_INT_PEND:     rd_mux = 32'(irq_s);
      default:               rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_hit = (s_axi_araddr <= `ELC_OFS_INT_PEND) &
                (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule : elc_ctrl

// *** pkg/elc_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef ELC_MAP_SVH
`define ELC_MAP_SVH
`define ELC_OFS_BRK_STATUS   8'h00
`define ELC_OFS_BRK_FLAG_CTL 8'h04
`define ELC_OFS_CONFIG       8'h08
`define ELC_OFS_CPU_STATE    8'h0C
`define ELC_OFS_INT_ENABLE   8'h10
`define ELC_OFS_INT_PEND     8'h14
`define ELC_BIT_BRK_WAIT     1
`define ELC_BIT_BREAK_FLAG_CLEAR_ENABLE         0
`define ELC_BIT_SHORT_STOP_RECOVERY_SEL        0
`define ELC_BIT_WDOG_DIS     1
`define ELC_RST_BRK_STATUS   8'h00
`define ELC_RST_BRK_FLAG_CTL 8'h00
`define ELC_RST_CONFIG       8'h00
`define ELC_REC_LONG         4096
`define ELC_REC_SHORT        32
`endif

// *** pkg/elc_pkg.sv ***
// Types shared by the exception and low-power control block
package elc_pkg;
  typedef enum logic [3:0] {
    ELC_RUN  = 4'b0001,
    ELC_WAIT = 4'b0010,
    ELC_STOP = 4'b0100,
    ELC_REC  = 4'b1000
  } elc_mode_t;
  typedef struct packed {
    logic       valid;
    logic       is_sw;
    logic [2:0] vec;
  } elc_irq_sel_t;
  typedef struct packed {
    logic       instr_done;
    logic       swi_exec;
    logic       wait_exec;
    logic       stop_exec;
    logic       rti_exec;
    logic       int_ack;
  } elc_cpu_evt_t;
endpackage : elc_pkg

// *** testbench/elc_chk_sva.sv ***
// Port-level assertions for the exception and low-power controller
`timescale 1ns/10ps
module elc_chk_sva (
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  int_rst_i,
  input wire elc_pkg::elc_cpu_evt_t cpu_evt_i,
  input wire logic                  flag_clr_req_i,
  input wire logic                  flag_clr_ok_o,
  input wire logic                  in_break_o,
  input wire logic                  int_mask_o,
  input wire elc_pkg::elc_irq_sel_t irq_sel_o,
  input wire logic                  pc_minus_one_o,
  input wire logic                  cpu_clk_en_o,
  input wire logic                  periph_clk_en_o,
  input wire logic                  base_clock_out_en_o,
  input wire logic                  crystal_clock_en_o,
  input wire logic [11:0]           rec_count_o
);
  import elc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // Assertions
  a_clr_gate: assert property (flag_clr_ok_o |-> flag_clr_req_i)
    else $error("flag clear passed without request");
  a_clr_free: assert property (
    flag_clr_req_i && !in_break_o |-> flag_clr_ok_o)
    else $error("flag clear blocked outside break");
  a_ack_mask: assert property (cpu_evt_i.int_ack |=> int_mask_o)
    else $error("mask not set at interrupt entry");
  a_lp_unmask: assert property (
    (cpu_evt_i.wait_exec || cpu_evt_i.stop_exec) && !cpu_evt_i.int_ack
    |=> !int_mask_o)
    else $error("mask not cleared by low-power entry");
  // Only service or a mask release may change a held latch
  a_latch_hold: assert property (
    irq_sel_o.valid && !cpu_evt_i.int_ack && !cpu_evt_i.rti_exec
    |=> $stable(irq_sel_o))
    else $error("latched interrupt preempted");
  a_pc_kind: assert property (
    irq_sel_o.valid |-> pc_minus_one_o == !irq_sel_o.is_sw)
    else $error("stacked PC kind wrong");
  a_swi_vec: assert property (
    cpu_evt_i.swi_exec && !irq_sel_o.valid |-> ##[1:2]
    (irq_sel_o.valid && irq_sel_o.is_sw && irq_sel_o.vec == 3'h7))
    else $error("software interrupt not latched");
  a_stop_gate: assert property (
    !base_clock_out_en_o |-> !cpu_clk_en_o && !periph_clk_en_o
    && !crystal_clock_en_o)
    else $error("clocks running in stop");
  a_stop_clr: assert property (
    cpu_evt_i.stop_exec |-> ##[1:3] rec_count_o == 12'h000)
    else $error("recovery counter not cleared by stop");
  a_cnt_step: assert property (
    $changed(rec_count_o) |-> rec_count_o == $past(rec_count_o) + 12'h001
    || rec_count_o == 12'h000)
    else $error("recovery counter skipped");
  a_cnt_free: assert property (
    cpu_clk_en_o && !int_rst_i |-> ##[1:24] $changed(rec_count_o))
    else $error("recovery counter not running");
  c_swi: cover property (cpu_evt_i.swi_exec ##[1:2] irq_sel_o.valid);
  c_break: cover property ($rose(in_break_o));
  c_wake: cover property (!base_clock_out_en_o ##1 base_clock_out_en_o);
endmodule : elc_chk_sva

// *** testbench/elc_core_model.sv ***
// Core model: instruction stream, forwarded commands, vector fetch
`timescale 1ns/10ps
module elc_core_model (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  cpu_clk_en_i,
  input  wire elc_pkg::elc_irq_sel_t irq_sel_i,
  input  wire logic [3:0]            cmd_i,
  output elc_pkg::elc_cpu_evt_t      cpu_evt_o
);
  import elc_pkg::*;
  logic [1:0] step_reg;
  logic [1:0] fetch_reg;
  logic       ack;
  // Stacking takes a few cycles, so the latch must hold meanwhile
  assign ack = irq_sel_i.valid && cpu_clk_en_i && fetch_reg == 2'h3;
  // Instructions complete only while the core is clocked
  assign cpu_evt_o = {cpu_clk_en_i && step_reg == 2'h3 && !ack,
                      cmd_i, ack};
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      step_reg  <= 2'h0;
      fetch_reg <= 2'h0;
    end else begin
      step_reg  <= cpu_clk_en_i ? step_reg + 2'h1 : 2'h0;
      fetch_reg <= (irq_sel_i.valid && !ack) ? fetch_reg + 2'h1 : 2'h0;
    end
  end
endmodule : elc_core_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the exception and low-power controller
`timescale 1ns/10ps
module tb_top;
  import elc_pkg::*;
  localparam int REC_L = 64;
  logic clk_i = 0, sys_rst_i = 1, pin_rst_i = 0, int_rst_i = 0;
  logic crystal_clock_i = 0, break_req_i = 0, flag_clr_req_i = 0;
  logic [7:0] irq_i = 8'h00;
  logic [3:0] cmd = 4'h0;
  elc_cpu_evt_t cpu_evt_i;
  elc_irq_sel_t irq_sel_o;
  logic flag_clr_ok_o, in_break_o, int_mask_o, pc_minus_one_o, vld_q;
  logic cpu_clk_en_o, periph_clk_en_o, base_clock_out_en_o;
  logic crystal_clock_en_o, watchdog_run_o;
  logic [11:0] rec_count_o;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0, tests_run = 0;
  logic [31:0] seed = 32'h7C20E3D8;
  logic [33:0] q_rd[$], q_wr[$];
  logic [4:0] q_irq[$];
  always #10 clk_i = ~clk_i;
  // Oscillator runs free, unrelated to the bus clock
  always #100 crystal_clock_i = ~crystal_clock_i;
  elc_ctrl #(.REC_LONG(REC_L)) i_elc_ctrl (.clk_i, .sys_rst_i, .pin_rst_i,
    .int_rst_i, .crystal_clock_i, .irq_i, .break_req_i, .cpu_evt_i,
    .flag_clr_req_i, .flag_clr_ok_o, .in_break_o, .int_mask_o, .irq_sel_o,
    .pc_minus_one_o, .cpu_clk_en_o, .periph_clk_en_o, .base_clock_out_en_o,
    .crystal_clock_en_o, .watchdog_run_o, .rec_count_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  elc_core_model i_elc_core_model (.clk_i, .sys_rst_i,
    .cpu_clk_en_i(cpu_clk_en_o), .irq_sel_i(irq_sel_o), .cmd_i(cmd),
    .cpu_evt_o(cpu_evt_i));
  // ==========================================================
  // Shared tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic chkb(input logic e, input logic g);
    chk({33'h0, e}, {33'h0, g});
  endtask : chkb
  task automatic summarize;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Command bits: 3 swi, 2 wait, 1 stop, 0 return
  task automatic evt(input int k);
    cmd <= 4'h1 << k;
    tick(1);
    cmd <= 4'h0;
  endtask : evt
  task automatic wt_mask(input logic v);
    for (int t = 0; t < 3000 && int_mask_o !== v; t++) tick(1);
  endtask : wt_mask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    // Only the four writable offsets answer OKAY
    q_wr.push_back((a == 8'h0C || a > 8'h10) ? 34'h2 : 34'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      tick(1);
      if (s_axi_awready === 1'b1 && !aw) aw = 1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1 && !w) w = 1;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do tick(1); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    q_rd.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do tick(1); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do tick(1); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // ==========================================================
  // Result monitor
  always @(posedge clk_i) begin
    if (s_axi_rvalid && s_axi_rready)
      chk(q_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk(q_wr.pop_front(), {32'h0, s_axi_bresp});
    if (irq_sel_o.valid && !vld_q)
      chk({29'h0, q_irq.pop_front()}, {29'h0, irq_sel_o.is_sw,
          irq_sel_o.vec, pc_minus_one_o});
    vld_q <= irq_sel_o.valid;
  end
  // ==========================================================
  // Scenarios
  initial begin
    logic [2:0] a, b, lo, hi;
    logic [11:0] r;
    int t, len;
    tick(6);
    sys_rst_i <= 1'b0;
    tick(1);
    chkb(1'b1, int_mask_o);
    axi_rd(8'h00, 34'h0);
    axi_rd(8'h04, 34'h0);
    axi_rd(8'h08, 34'h0);
    axi_rd(8'h20, {2'h2, 32'h0});
    axi_wr(8'h10, 32'h0000_00FF);
    axi_wr(8'h0C, 32'h0);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      a = seed[2:0];
      b = (seed[5:3] == a) ? a + 3'h1 : seed[5:3];
      lo = (a < b) ? a : b;
      hi = (a < b) ? b : a;
      evt(2);
      tick(2);
      chkb(1'b0, int_mask_o);
      chkb(1'b0, cpu_clk_en_o);
      chkb(1'b1, periph_clk_en_o);
      chkb(1'b1, watchdog_run_o);
      q_irq.push_back({1'b0, lo, 1'b1});
      q_irq.push_back({1'b0, hi, 1'b1});
      irq_i <= (8'h01 << a) | (8'h01 << b);
      wt_mask(1'b1);
      irq_i <= 8'h01 << hi;
      tick(8);
      chkb(1'b0, irq_sel_o.valid);
      evt(0);
      tick(2);
      wt_mask(1'b1);
      irq_i <= 8'h00;
      tick(4);
    end
    q_irq.push_back({1'b1, 3'h7, 1'b0});
    evt(3);
    tick(12);
    evt(2);
    tick(2);
    q_irq.push_back({1'b1, 3'h7, 1'b0});
    break_req_i <= 1'b1;
    flag_clr_req_i <= 1'b1;
    tick(6);
    chkb(1'b1, in_break_o);
    chkb(1'b0, flag_clr_ok_o);
    axi_wr(8'h04, 32'h1);
    chkb(1'b1, flag_clr_ok_o);
    axi_wr(8'h04, 32'h0);
    chkb(1'b0, flag_clr_ok_o);
    break_req_i <= 1'b0;
    tick(8);
    evt(0);
    tick(1);
    chkb(1'b0, in_break_o);
    chkb(1'b1, flag_clr_ok_o);
    axi_rd(8'h00, 34'h2);
    axi_wr(8'h00, 32'h0);
    axi_rd(8'h00, 34'h0);
    // Select bit is flipped after stop entry: only the wake-time value counts
    for (int i = 0; i < 2; i++) begin
      len = (i == 0) ? 32 : REC_L;
      axi_wr(8'h08, {31'h0, i[0]});
      evt(1);
      axi_wr(8'h08, {31'h0, ~i[0]});
      tick(30);
      chkb(1'b0, base_clock_out_en_o);
      chkb(1'b0, crystal_clock_en_o);
      chk(34'h0, {22'h0, rec_count_o});
      q_irq.push_back({1'b0, 3'h0, 1'b1});
      irq_i <= 8'h01;
      for (t = 0; t < 2000 && cpu_clk_en_o !== 1'b1; t++) tick(1);
      chkb(1'b1, t >= 10 * len - 12 && t <= 10 * len + 25);
      wt_mask(1'b1);
      irq_i <= 8'h00;
      tick(4);
    end
    axi_wr(8'h08, 32'h2);
    chkb(1'b0, watchdog_run_o);
    evt(0);
    tick(30);
    r = rec_count_o;
    pin_rst_i <= 1'b1;
    tick(5);
    pin_rst_i <= 1'b0;
    tick(5);
    chkb(1'b1, rec_count_o !== 12'h000 && rec_count_o >= r);
    chkb(1'b1, int_mask_o);
    int_rst_i <= 1'b1;
    tick(1);
    int_rst_i <= 1'b0;
    tick(2);
    chkb(1'b1, rec_count_o <= 12'h001);
    tick(30);
    summarize();
  end
  // Run is under two thousand cycles; this bound leaves wide margin
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule : tb_top
bind elc_ctrl elc_chk_sva i_elc_chk_sva (.clk_i, .sys_rst_i, .int_rst_i,
  .cpu_evt_i, .flag_clr_req_i, .flag_clr_ok_o, .in_break_o, .int_mask_o,
  .irq_sel_o, .pc_minus_one_o, .cpu_clk_en_o, .periph_clk_en_o,
  .base_clock_out_en_o, .crystal_clock_en_o, .rec_count_o);
